// [src/epdaf_defs.svh]
`ifndef EPDAF_DEFS_SVH
`define EPDAF_DEFS_SVH
`define EPDAF_OFF_DIR 12'h000
`define EPDAF_OFF_FSEL 12'h004
`define EPDAF_OFF_DATA 12'h008
`define EPDAF_RST_DIR 8'h00
`define EPDAF_RST_FSEL 8'h00
`define EPDAF_RST_DATA 8'h00
`define EPDAF_IMPL_MASK 8'hf7
`define EPDAF_RX_BIT 0
`define EPDAF_NUM_PINS 8
`endif

// [src/epdaf_pkg.sv]
`include "epdaf_defs.svh"
package epdaf_pkg;
	typedef logic [7:0] epdaf_byte_t;
	typedef logic [31:0] epdaf_word_t;
	typedef logic [11:0] epdaf_addr_t;
	typedef enum logic [1:0] {
		EPDAF_IDLE = 2'b01,
		EPDAF_ACCESS = 2'b10
	} epdaf_phase_e;
	typedef struct packed {
		epdaf_phase_e phase;
		epdaf_byte_t dir;
		epdaf_byte_t fsel;
		epdaf_byte_t data;
		epdaf_word_t rdata;
	} epdaf_regs_s;
	typedef struct packed {
		epdaf_byte_t s1;
		epdaf_byte_t s2;
	} epdaf_sync_s;
endpackage

// [src/epdaf_sync.sv]
`include "epdaf_defs.svh"
module epdaf_sync
	import epdaf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw and synchronised pins
	input wire logic [7:0] din,
	output logic [7:0] dout
);
	epdaf_sync_s st_r;
	epdaf_sync_s st_nxt;
	always_comb
	begin
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign dout = st_r.s2;
endmodule

// [src/epdaf_port.sv]
// Behaviour
// - A direction bit of 0 makes its pin an input and 1 makes it an output.
// - Reset clears the direction register so every pin starts as an input.
// - A function select bit of 0 picks the primary function and 1 the secondary.
// - Reset clears the function select register so every pin starts on its primary function.
// - Pin 0 has no secondary function and always feeds the serial receive input, whatever its direction.
// - The data register holds one bit per pin and clears to zero on reset.
// - Reading data returns live pin level for input pins and the latched value for output pins.
// - Writing data updates all eight latched bits regardless of direction.
`include "epdaf_defs.svh"
module epdaf_port
	import epdaf_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire epdaf_pkg::epdaf_addr_t PADDR,
	input wire epdaf_pkg::epdaf_word_t PWDATA,
	input wire logic [3:0] PSTRB,
	output epdaf_pkg::epdaf_word_t PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Port pins, enable low while driving
	input wire epdaf_pkg::epdaf_byte_t PIN_IN,
	output epdaf_pkg::epdaf_byte_t PIN_OUT,
	output epdaf_pkg::epdaf_byte_t PIN_OE_N,
	// Secondary function sources and routing
	input wire epdaf_pkg::epdaf_byte_t ALT_OUT,
	output epdaf_pkg::epdaf_byte_t ALT_SEL,
	output logic SERIAL_RECEIVE_IN
);
	import epdaf_pkg::*;

	epdaf_regs_s st_r;
	epdaf_regs_s st_nxt;
	epdaf_byte_t pins_sync;
	epdaf_byte_t drv;
	logic setup;
	logic wr_lo;

	function automatic logic known_addr(input epdaf_addr_t a);
		known_addr = (a == `EPDAF_OFF_DIR) || (a == `EPDAF_OFF_FSEL) || (a == `EPDAF_OFF_DATA);
	endfunction

	// Pins are asynchronous to the core clock
	epdaf_sync u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.din(PIN_IN),
		.dout(pins_sync)
	);

	assign setup = PSEL && !PENABLE;
	// Registers live in byte lane 0; a write without that strobe is ignored
	assign wr_lo = PSEL && PENABLE && PWRITE && PSTRB[0] && (st_r.phase == EPDAF_ACCESS);

	always_comb
	begin
		st_nxt = st_r;
		case (st_r.phase)
			EPDAF_IDLE:
			begin
				if (setup)
					st_nxt.phase = EPDAF_ACCESS;
				if (setup && !PWRITE)
				begin
					st_nxt.rdata = '0;
					case (PADDR)
						`EPDAF_OFF_DIR: st_nxt.rdata[7:0] = st_r.dir & `EPDAF_IMPL_MASK;
						`EPDAF_OFF_FSEL: st_nxt.rdata[7:0] = st_r.fsel & `EPDAF_IMPL_MASK;
						// Input bits show the live level, output bits the latch
						`EPDAF_OFF_DATA: st_nxt.rdata[7:0] = (pins_sync & ~st_r.dir) | (st_r.data & st_r.dir);
						default: st_nxt.rdata = '0;
					endcase
				end
			end
			EPDAF_ACCESS:
			begin
				st_nxt.phase = EPDAF_IDLE;
				if (wr_lo)
				begin
					case (PADDR)
						`EPDAF_OFF_DIR: st_nxt.dir = PWDATA[7:0] & `EPDAF_IMPL_MASK;
						`EPDAF_OFF_FSEL: st_nxt.fsel = PWDATA[7:0] & `EPDAF_IMPL_MASK;
						`EPDAF_OFF_DATA: st_nxt.data = PWDATA[7:0];
						default: st_nxt.data = st_r.data;
					endcase
				end
			end
			default: st_nxt.phase = EPDAF_IDLE;
		endcase
		// Pin 0 is the serial receive pin and never takes a secondary function
		st_nxt.fsel[`EPDAF_RX_BIT] = 1'b0;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			st_r.phase <= EPDAF_IDLE;
			st_r.dir <= `EPDAF_RST_DIR;
			st_r.fsel <= `EPDAF_RST_FSEL;
			st_r.data <= `EPDAF_RST_DATA;
			st_r.rdata <= '0;
		end
		else
			st_r <= st_nxt;
	end

	genvar g;
	generate
		for (g = 0; g < `EPDAF_NUM_PINS; g++)
		begin : g_pin
			// Secondary output replaces the latch whenever the pin's function select bit is set, whatever its direction
			assign drv[g] = st_r.fsel[g] ? ALT_OUT[g] : st_r.data[g];
			assign PIN_OE_N[g] = ~st_r.dir[g];
		end
	endgenerate

	// Read data is registered in the setup cycle, so one access cycle suffices
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !known_addr(PADDR);
	assign PRDATA = st_r.rdata;
	assign PIN_OUT = drv;
	assign ALT_SEL = st_r.fsel;
	assign SERIAL_RECEIVE_IN = pins_sync[`EPDAF_RX_BIT];
endmodule

// [tb/epdaf_checker.sv]
module epdaf_checker
	import epdaf_pkg::*;
(
	// Clock, reset and bus
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PSLVERR,
	// Pins
	input wire logic [7:0] PIN_IN,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE_N,
	input wire logic [7:0] ALT_OUT,
	input wire logic [7:0] ALT_SEL,
	input wire logic SERIAL_RECEIVE_IN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	wire wr = PSEL && PENABLE && PWRITE && PSTRB[0];
	dir_wr_a: assert property (wr && PADDR == 12'h0 |=> ~PIN_OE_N == ($past(PWDATA[7:0]) & 8'hf7))
		else $error("dir");
	fsel_wr_a: assert property (wr && PADDR == 12'h4 |=> ALT_SEL == ($past(PWDATA[7:0]) & 8'hf6))
		else $error("fsel");
	data_wr_a: assert property (wr && PADDR == 12'h8 |=> ((PIN_OUT ^ $past(PWDATA[7:0])) & ~ALT_SEL) == 8'h0)
		else $error("data");
	alt_pin_a: assert property (((PIN_OUT ^ ALT_OUT) & ALT_SEL) == 8'h0) else $error("alt");
	rst_val_a: assert property (disable iff (1'b0) RST |=> PIN_OE_N == 8'hff && ALT_SEL == 8'h0 && PIN_OUT == 8'h0)
		else $error("reset");
	bad_addr_a: assert property (PSEL && PENABLE && !(PADDR inside {12'h0, 12'h4, 12'h8}) |-> PSLVERR)
		else $error("slverr");
	rx_pin_a: assert property (SERIAL_RECEIVE_IN == $past(PIN_IN[0], 2)) else $error("rx");
endmodule
bind epdaf_port epdaf_checker u_chk (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PSTRB(PSTRB),
	.PSLVERR(PSLVERR),
	.PIN_IN(PIN_IN),
	.PIN_OUT(PIN_OUT),
	.PIN_OE_N(PIN_OE_N),
	.ALT_OUT(ALT_OUT),
	.ALT_SEL(ALT_SEL),
	.SERIAL_RECEIVE_IN(SERIAL_RECEIVE_IN)
);

// [tb/tb_eight_bit_port_direction_altfunc.sv]
module tb_eight_bit_port_direction_altfunc
	import epdaf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CORE_CLK = 1'h0;
	logic RST = 1'h1;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic PREADY, PSLVERR, SERIAL_RECEIVE_IN, err;
	logic [3:0] PSTRB = 4'hf;
	epdaf_addr_t PADDR = 12'h0;
	epdaf_word_t PWDATA = 32'h0, PRDATA, rd;
	epdaf_byte_t PIN_IN = 8'h0, ALT_OUT = 8'ha5, PIN_OUT, PIN_OE_N, ALT_SEL;
	int errors = 0, samples_checked = 0;
	epdaf_port u_dut (
		.CORE_CLK(CORE_CLK),
		.RST(RST),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PSTRB(PSTRB),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.PIN_IN(PIN_IN),
		.PIN_OUT(PIN_OUT),
		.PIN_OE_N(PIN_OE_N),
		.ALT_OUT(ALT_OUT),
		.ALT_SEL(ALT_SEL),
		.SERIAL_RECEIVE_IN(SERIAL_RECEIVE_IN)
	);
	initial forever #10 CORE_CLK = ~CORE_CLK;
	task automatic end_sim();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input epdaf_word_t g, input epdaf_word_t e);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Holds the request until ready is seen high at an edge
	task automatic bus(input logic w, input epdaf_addr_t a, input epdaf_byte_t d);
		int n;
		@(posedge CORE_CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		for (n = 0; n < 9 && PREADY !== 1'h1; n++)
			@(posedge CORE_CLK);
		if (n == 9)
		begin
			errors++;
			end_sim();
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	task automatic t_reset();
		bus(1'h0, 12'h0, 8'h0);
		chk(rd, 32'h0);
		bus(1'h0, 12'h4, 8'h0);
		chk(rd, 32'h0);
		bus(1'h0, 12'h8, 8'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_dir();
		bus(1'h1, 12'h0, 8'hff);
		bus(1'h1, 12'h4, 8'hff);
		bus(1'h0, 12'h0, 8'h0);
		chk(rd, 32'hf7);
		bus(1'h0, 12'h4, 8'h0);
		chk(rd, 32'hf6);
		chk(PIN_OE_N, 32'h08);
		chk(PIN_OUT, 32'ha4);
		// A fixed secondary source would hide a mux stuck on one value
		ALT_OUT <= 8'h5a;
		@(posedge CORE_CLK);
		chk(PIN_OUT, 32'h52);
	endtask
	task automatic t_data();
		bus(1'h1, 12'h4, 8'h0);
		bus(1'h1, 12'h0, 8'hf0);
		PIN_IN <= 8'h5a;
		bus(1'h1, 12'h8, 8'h3c);
		bus(1'h0, 12'h8, 8'h0);
		chk(rd, 32'h3a);
		chk(PIN_OUT, 32'h3c);
		bus(1'h0, 12'hc, 8'h0);
		chk(err, 32'h1);
		// Lane 0 strobe low must leave the latch alone
		PSTRB <= 4'he;
		bus(1'h1, 12'h8, 8'hff);
		PSTRB <= 4'hf;
		chk(PIN_OUT, 32'h3c);
		// Pin 0 high so the receive path is seen to move
		PIN_IN <= 8'ha5;
		repeat (3) @(posedge CORE_CLK);
		chk(SERIAL_RECEIVE_IN, 32'h1);
		bus(1'h0, 12'h8, 8'h0);
		chk(rd, 32'h35);
	endtask
	initial
	begin
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'h0;
		t_reset();
		t_dir();
		t_data();
		end_sim();
	end
endmodule
